//--- rtl/clk_ctrl_defs.svh
/*
 * Constants for the clock output control block.
 * Assumes inclusion by bare name from package and modules.
 */
// What this block does
// R1 - Status change raises interrupt
// R2 - Per-indicator mask blocks interrupt
// R3 - Interrupt releases only after host clear
// R4 - Crosspoint routes any synthesizer to any driver
// R5 - Single-ended pins in phase, polarity selectable
// R6 - Enable pin high disables all drivers
// R7 - Per-output register disable bit
// R8 - Disabled level selectable low or high
// R9 - Synchronous disable waits period end
// R10 - Asynchronous disable stops clock at once
// R11 - Zero-delay uses external feedback, no hitless
// R12 - Dividers reset at power-up and reset
// R13 - Defaults load from storage before clocks
// R14 - Storage accepts two writes, newest only
// R15 - Select pin picks I2C or SPI
// R16 - SPI four-wire or three-wire variants
// R17 - Drive strength codes 1, 2, 3
// R18 - Live and sticky status registers
// R19 - Interrupt active low while unmasked sticky set
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH
`define NUM_STATUS 4
`define NUM_OUTPUTS 10
`define NUM_SYNTH 5
`define SYNTH_SEL_W 3
`define DRV_W 2
`define DRV_DEFAULT 2'h3
`define DRV_WEAK 2'h1
`define NVM_SLOTS 2
`define NVM_SLOT_W 2
`define CFG_W 16
`define LOAD_CYCLES 8'h10
`define LOAD_CNT_W 8
`endif

//--- rtl/clk_ctrl_pkg.sv
/*
 * Types for the clock output control block.
 * Assumes the constants header is on the include path.
 */
`include "clk_ctrl_defs.svh"
package clk_ctrl_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_LOAD = 4'h2,
        ST_RUN = 4'h4,
        ST_IDLE_UNUSED = 4'h8
    } init_state_type;
endpackage : clk_ctrl_pkg

//--- rtl/output_driver.sv
/*
 * One output driver: enable gating, parked level, polarity, sync disable.
 * Assumes its synthesizer clock is a level sampled in the core_clk domain.
 */
`include "clk_ctrl_defs.svh"
module output_driver
    import clk_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic src_clk,
    input wire logic enable,
    input wire logic park_high,
    input wire logic sync_dis,
    input wire logic invert_pos,
    input wire logic invert_neg,
    output logic clk_out_pos,
    output logic clk_out_neg,
    output logic running
);
    logic src_prev;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src_clk;
        end
    end

    // Gate opens at once; closes at period end or at once
    always_ff @(posedge core_clk) begin
        if (rst) begin
            running <= 1'b0;
        end else if (enable) begin
            running <= 1'b1;
        end else if (!sync_dis) begin
            running <= 1'b0; // R10
        end else if (src_prev && !src_clk) begin
            running <= 1'b0; // R9
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_out_pos <= 1'b0;
            clk_out_neg <= 1'b0;
        end else if (running && (enable || !sync_dis || src_clk)) begin
            clk_out_pos <= src_clk ^ invert_pos; // R5
            clk_out_neg <= src_clk ^ invert_neg; // R5
        end else begin
            clk_out_pos <= park_high; // R8
            clk_out_neg <= park_high; // R8
        end
    end
endmodule : output_driver

//--- rtl/status_irq.sv
/*
 * Status change detection, sticky bits, masking and interrupt pin.
 * Assumes status flags come from the fault monitors, async to core_clk.
 */
`include "clk_ctrl_defs.svh"
module status_irq
    import clk_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`NUM_STATUS-1:0] status_raw,
    input wire logic [`NUM_STATUS-1:0] irq_mask,
    input wire logic [`NUM_STATUS-1:0] sticky_clear,
    output logic [`NUM_STATUS-1:0] status_live,
    output logic [`NUM_STATUS-1:0] status_sticky,
    output logic status_irq_n
);
    logic [`NUM_STATUS-1:0] sync_a;
    logic [`NUM_STATUS-1:0] live_prev;
    logic [`NUM_STATUS-1:0] change;

    // Two-stage synchroniser; second stage is the live view
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_a <= '0;
            status_live <= '0;
        end else begin
            sync_a <= status_raw;
            status_live <= sync_a; // R18
        end
    end

    // Only settled live bits feed the change detector
    always_ff @(posedge core_clk) begin
        if (rst) begin
            live_prev <= '0;
        end else begin
            live_prev <= status_live;
        end
    end

    assign change = status_live ^ live_prev;

    // Set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_sticky <= '0;
        end else begin
            status_sticky <= (status_sticky & ~sticky_clear) | change; // R18 R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_irq_n <= 1'b1;
        end else begin
            status_irq_n <= ~|(status_sticky & ~irq_mask); // R2 R3 R19
        end
    end
endmodule : status_irq

//--- rtl/clock_output_ctrl.sv
/*
 * Top of the clock output control layer: init sequencing, storage
 * defaults, crosspoint, drivers, interface selection, status interrupt.
 * Assumes synthesizer clocks are slow levels and config arrives as ports.
 */
`include "clk_ctrl_defs.svh"
module clock_output_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int NUM_OUT = `NUM_OUTPUTS,
    parameter int NUM_SYN = `NUM_SYNTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic device_reset_n,
    input wire logic hard_reset,
    input wire logic [NUM_SYN-1:0] synth_clk,
    input wire logic external_feedback_in,
    input wire logic global_output_en_n,
    input wire logic bus_select_i2c,
    input wire logic spi_three_wire,
    input wire logic [`NUM_STATUS-1:0] status_raw,
    input wire logic [`NUM_STATUS-1:0] irq_mask,
    input wire logic [`NUM_STATUS-1:0] sticky_clear,
    input wire logic [NUM_OUT-1:0] out_disable,
    input wire logic [NUM_OUT-1:0] park_high,
    input wire logic [NUM_OUT-1:0] sync_dis,
    input wire logic [NUM_OUT-1:0] invert_pos,
    input wire logic [NUM_OUT-1:0] invert_neg,
    input wire logic [NUM_OUT*`SYNTH_SEL_W-1:0] route_sel,
    input wire logic [NUM_OUT*`DRV_W-1:0] single_ended_drive_sel,
    input wire logic zero_delay_en,
    input wire logic hitless_req,
    input wire logic nvm_write,
    input wire logic [`CFG_W-1:0] nvm_write_data,
    output logic [NUM_OUT-1:0] clk_out_pos,
    output logic [NUM_OUT-1:0] clk_out_neg,
    output logic [NUM_OUT*`DRV_W-1:0] drive_strength,
    output logic divider_reset,
    output logic clocks_running,
    output logic [`CFG_W-1:0] default_config,
    output logic [`NVM_SLOT_W-1:0] nvm_writes_used,
    output logic nvm_write_refused,
    output logic feedback_sel_ext,
    output logic hitless_active,
    output logic iface_i2c,
    output logic iface_spi4,
    output logic iface_spi3,
    output logic [`NUM_STATUS-1:0] status_live,
    output logic [`NUM_STATUS-1:0] status_sticky,
    output logic status_irq_n,
    output logic last_clock_output
);
    parameter logic [`CFG_W-1:0] FACTORY_CONFIG = 16'h0000;

    init_state_type state;
    logic [1:0] rstn_sync;
    logic [1:0] oe_sync;
    logic [1:0] sel_sync;
    logic [1:0] spi3_sync;
    logic [1:0] fb_sync;
    logic [NUM_SYN-1:0] syn_a;
    logic [NUM_SYN-1:0] syn_b;
    logic [`LOAD_CNT_W-1:0] load_cnt;
    logic [`CFG_W-1:0] nvm_slot [`NVM_SLOTS];
    logic [NUM_OUT-1:0] drv_pos;
    logic [NUM_OUT-1:0] drv_neg;
    logic [NUM_OUT-1:0] drv_src;
    logic [NUM_OUT-1:0] drv_en;
    logic reset_req;

    // Pick one synthesizer for a driver
    function automatic logic pick_synth(
        input logic [NUM_SYN-1:0] clks,
        input logic [`SYNTH_SEL_W-1:0] sel
    );
        pick_synth = (int'(sel) < NUM_SYN) ? clks[sel] : 1'b0;
    endfunction : pick_synth

    // Clamp drive code into 1..3
    function automatic logic [`DRV_W-1:0] clamp_drive(
        input logic [`DRV_W-1:0] code
    );
        clamp_drive = (code == 2'h0) ? `DRV_WEAK : code;
    endfunction : clamp_drive

    // Pin reset synchroniser
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rstn_sync <= 2'h0;
        end else begin
            rstn_sync <= {rstn_sync[0], device_reset_n};
        end
    end

    // Output enable pin synchroniser, idles disabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oe_sync <= 2'h3;
        end else begin
            oe_sync <= {oe_sync[0], global_output_en_n};
        end
    end

    // Interface select synchronisers, idle matches I2C default
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_sync <= 2'h3;
            spi3_sync <= 2'h0;
        end else begin
            sel_sync <= {sel_sync[0], bus_select_i2c};
            spi3_sync <= {spi3_sync[0], spi_three_wire};
        end
    end

    // Feedback pin synchroniser
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fb_sync <= 2'h0;
        end else begin
            fb_sync <= {fb_sync[0], external_feedback_in};
        end
    end

    // Synthesizer clock synchronisers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syn_a <= '0;
            syn_b <= '0;
        end else begin
            syn_a <= synth_clk;
            syn_b <= syn_a;
        end
    end

    assign reset_req = !rstn_sync[1] || hard_reset;

    // Power-up and reset sequencing
    always_ff @(posedge core_clk) begin
        if (rst || reset_req) begin
            state <= ST_RESET; // R12
            load_cnt <= '0;
        end else begin
            case (state)
                ST_RESET: begin
                    state <= ST_LOAD;
                    load_cnt <= '0;
                end
                ST_LOAD: begin
                    load_cnt <= load_cnt + `LOAD_CNT_W'(1);
                    if (load_cnt == `LOAD_CYCLES) begin
                        state <= ST_RUN; // R13
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // Dividers held until the run state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            divider_reset <= 1'b1;
        end else begin
            divider_reset <= (state != ST_RUN) || reset_req; // R12
        end
    end

    // Clocks flagged only after defaults are loaded
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clocks_running <= 1'b0;
        end else begin
            clocks_running <= (state == ST_RUN) && !reset_req; // R13
        end
    end

    // Storage: two writes, newest slot only visible
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nvm_writes_used <= '0;
            nvm_write_refused <= 1'b0;
            nvm_slot[0] <= 16'h0000;
            nvm_slot[1] <= 16'h0000;
        end else begin
            nvm_write_refused <= 1'b0;
            if (nvm_write) begin
                if (nvm_writes_used < `NVM_SLOT_W'(`NVM_SLOTS)) begin
                    nvm_slot[nvm_writes_used[0]] <= nvm_write_data; // R14
                    nvm_writes_used <= nvm_writes_used + `NVM_SLOT_W'(1);
                end else begin
                    nvm_write_refused <= 1'b1; // R14
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            default_config <= '0;
        end else if (state == ST_LOAD) begin
            if (nvm_writes_used == 2'h0) begin
                default_config <= FACTORY_CONFIG; // R13
            end else begin
                default_config <= nvm_slot[nvm_writes_used[0] ^ 1'b1]; // R14
            end
        end
    end

    // Interface selection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            iface_i2c <= 1'b1;
            iface_spi4 <= 1'b0;
            iface_spi3 <= 1'b0;
        end else begin
            iface_i2c <= sel_sync[1]; // R15
            iface_spi4 <= !sel_sync[1] && !spi3_sync[1]; // R16
            iface_spi3 <= !sel_sync[1] && spi3_sync[1]; // R16
        end
    end

    // Zero-delay feedback path
    always_ff @(posedge core_clk) begin
        if (rst) begin
            feedback_sel_ext <= 1'b0;
            hitless_active <= 1'b0;
        end else begin
            feedback_sel_ext <= zero_delay_en; // R11
            hitless_active <= hitless_req && !zero_delay_en; // R11
        end
    end

    // Feedback pin echo, quiet outside zero-delay mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_clock_output <= 1'b0;
        end else begin
            last_clock_output <= zero_delay_en ? fb_sync[1] : 1'b0; // R11
        end
    end

    // Drive strength per output
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_strength <= {NUM_OUT{`DRV_DEFAULT}};
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                drive_strength[i*`DRV_W +: `DRV_W] <=
                    clamp_drive(single_ended_drive_sel[i*`DRV_W +: `DRV_W]); // R17
            end
        end
    end

    // Crosspoint and enable gating
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            drv_src[i] = pick_synth(syn_b,
                route_sel[i*`SYNTH_SEL_W +: `SYNTH_SEL_W]); // R4
            drv_en[i] = !oe_sync[1] && !out_disable[i] // R6 R7
                && (state == ST_RUN);
        end
    end

    for (genvar g = 0; g < NUM_OUT; g++) begin : g_drv
        output_driver u_drv (
            .core_clk(core_clk),
            .rst(rst || divider_reset),
            .src_clk(drv_src[g]),
            .enable(drv_en[g]),
            .park_high(park_high[g]),
            .sync_dis(sync_dis[g]),
            .invert_pos(invert_pos[g]),
            .invert_neg(invert_neg[g]),
            .clk_out_pos(drv_pos[g]),
            .clk_out_neg(drv_neg[g]),
            .running()
        );
    end

    // Registered pin outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_out_pos <= '0;
            clk_out_neg <= '0;
        end else begin
            clk_out_pos <= drv_pos;
            clk_out_neg <= drv_neg;
        end
    end

    status_irq u_irq (
        .core_clk(core_clk),
        .rst(rst),
        .status_raw(status_raw),
        .irq_mask(irq_mask),
        .sticky_clear(sticky_clear),
        .status_live(status_live),
        .status_sticky(status_sticky),
        .status_irq_n(status_irq_n)
    );
endmodule : clock_output_ctrl

//--- sim/clock_output_ctrl_asserts.sv
/*
 * Port-level assertions for the clock output control top.
 * Assumes it is bound into clock_output_ctrl with the same parameters.
 */
`include "clk_ctrl_defs.svh"
module clock_output_ctrl_asserts
    import clk_ctrl_pkg::*;
#(
    parameter int NUM_OUT = `NUM_OUTPUTS,
    parameter int NUM_SYN = `NUM_SYNTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hard_reset,
    input wire logic global_output_en_n,
    input wire logic bus_select_i2c,
    input wire logic spi_three_wire,
    input wire logic [`NUM_STATUS-1:0] irq_mask,
    input wire logic [`NUM_STATUS-1:0] sticky_clear,
    input wire logic [NUM_OUT-1:0] park_high,
    input wire logic [NUM_OUT*`DRV_W-1:0] single_ended_drive_sel,
    input wire logic nvm_write,
    input wire logic [NUM_OUT-1:0] clk_out_pos,
    input wire logic [NUM_OUT-1:0] clk_out_neg,
    input wire logic [NUM_OUT*`DRV_W-1:0] drive_strength,
    input wire logic divider_reset,
    input wire logic clocks_running,
    input wire logic [`NVM_SLOT_W-1:0] nvm_writes_used,
    input wire logic nvm_write_refused,
    input wire logic feedback_sel_ext,
    input wire logic hitless_active,
    input wire logic iface_i2c,
    input wire logic iface_spi4,
    input wire logic iface_spi3,
    input wire logic [`NUM_STATUS-1:0] status_live,
    input wire logic [`NUM_STATUS-1:0] status_sticky,
    input wire logic status_irq_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PARK_WAIT = 40;
    logic [`NUM_STATUS-1:0] live_q;
    logic [`NUM_STATUS-1:0] chg;
    logic [7:0] off_cnt;
    logic [NUM_OUT*2-1:0] drv_exp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Live status edges
    assign chg = status_live ^ live_q;
    always_ff @(posedge core_clk) begin
        live_q <= status_live;
    end
    // Cycles spent globally disabled while running
    always_ff @(posedge core_clk) begin
        if (rst || !global_output_en_n || !clocks_running) begin
            off_cnt <= 8'h00;
        end else if (off_cnt != 8'(PARK_WAIT)) begin
            off_cnt <= off_cnt + 8'h01;
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            drv_exp[i*2 +: 2] = single_ended_drive_sel[i*2 +: 2];
            if (drv_exp[i*2 +: 2] == 2'h0) begin
                drv_exp[i*2 +: 2] = 2'h1;
            end
        end
    end
    sequence sel_steady;
        $stable(bus_select_i2c) && $stable(spi_three_wire);
    endsequence
    chk_irq_level: assert property (
        status_irq_n == !$past(|(status_sticky & ~irq_mask)))
        else $error("interrupt pin level wrong");
    chk_sticky_set: assert property (
        (chg != 4'h0) |=> ((status_sticky & $past(chg)) == $past(chg)))
        else $error("status change did not set sticky");
    chk_sticky_hold: assert property (
        ($past(status_sticky) & ~$past(sticky_clear) & ~status_sticky)
        == 4'h0)
        else $error("sticky bit dropped without clear");
    chk_sticky_cause: assert property (
        (status_sticky & ~$past(status_sticky) & ~$past(chg)) == 4'h0)
        else $error("sticky bit set without change");
    chk_park_level: assert property (
        (off_cnt == 8'(PARK_WAIT)) |->
        (clk_out_pos == park_high) && (clk_out_neg == park_high))
        else $error("disabled outputs not at parked level");
    chk_drive_code: assert property (
        drive_strength == $past(drv_exp))
        else $error("drive strength wrong");
    chk_iface_sel: assert property (
        sel_steady [*5] |-> (iface_i2c == bus_select_i2c) &&
        (iface_spi4 == (!bus_select_i2c && !spi_three_wire)) &&
        (iface_spi3 == (!bus_select_i2c && spi_three_wire)))
        else $error("interface selection wrong");
    chk_zero_hitless: assert property (
        feedback_sel_ext |-> !hitless_active)
        else $error("hitless active in zero delay mode");
    chk_nvm_third: assert property (
        (nvm_write && nvm_writes_used == 2'h2) |=> nvm_write_refused)
        else $error("third storage write not refused");
    chk_div_hard: assert property (
        hard_reset |-> ##[1:2] divider_reset)
        else $error("dividers not reset on hard reset");
endmodule : clock_output_ctrl_asserts

bind clock_output_ctrl clock_output_ctrl_asserts #(
    .NUM_OUT(NUM_OUT),
    .NUM_SYN(NUM_SYN)
) u_chk (.*);

//--- sim/host_model.sv
/*
 * Host side: synthesizer clock sources and interrupt service.
 * Assumes one core clock and a bench enable for servicing.
 */
module host_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic service_en,
    input wire logic status_irq_n,
    input wire logic [3:0] status_sticky,
    output logic [4:0] synth_clk,
    output logic [3:0] sticky_clear
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt;
    assign synth_clk = cnt;
    always_ff @(posedge core_clk) begin
        cnt <= rst ? 5'h00 : cnt + 5'h01;
    end
    // Clear what caused the interrupt
    always_ff @(posedge core_clk) begin
        if (rst || !service_en || status_irq_n) begin
            sticky_clear <= 4'h0;
        end else begin
            sticky_clear <= status_sticky;
        end
    end
endmodule : host_model

//--- sim/tb.sv
/*
 * Self-checking bench for the clock output control top.
 * Assumes the host model supplies clocks and interrupt service.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst = 1'b1, device_reset_n = 1'b1;
    logic hard_reset = 1'b0, global_output_en_n = 1'b0;
    logic bus_select_i2c = 1'b1, spi_three_wire = 1'b0, service_en = 1'b0;
    logic zero_delay_en = 1'b0, hitless_req = 1'b0, nvm_write = 1'b0;
    logic [3:0] status_raw = 4'h0, irq_mask = 4'h0;
    logic [9:0] out_disable = 10'h000, park_high = 10'h000;
    logic [9:0] sync_dis = 10'h000, invert_pos = 10'h000;
    logic [9:0] invert_neg = 10'h000, clk_out_pos, clk_out_neg;
    logic [29:0] route_sel = 30'h0;
    logic [19:0] single_ended_drive_sel = 20'hFFFFF, drive_strength;
    logic [15:0] nvm_write_data = 16'h0000, default_config;
    logic [4:0] synth_clk;
    logic [3:0] sticky_clear, status_live, status_sticky;
    logic [1:0] nvm_writes_used;
    logic divider_reset, clocks_running, nvm_write_refused, status_irq_n;
    logic feedback_sel_ext, hitless_active, iface_i2c, iface_spi4;
    logic iface_spi3, last_clock_output, external_feedback_in;
    int error_cnt = 0, total_checks = 0;
    assign external_feedback_in = clk_out_pos[9];
    clock_output_ctrl dut (.*);
    host_model host (.*);
    initial forever #2 core_clk = ~core_clk;
    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : look
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task final_report;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        look(10);
        chk(clocks_running, 0);
        look(30);
        chk(clocks_running, 1);
        chk(default_config, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            status_raw[i] <= 1'b1;
            look(6);
            chk({status_irq_n, status_sticky[i]}, 2'h1);
            @(posedge core_clk);
            service_en <= 1'b1;
            look(6);
            chk({status_irq_n, status_sticky}, 5'h10);
            @(posedge core_clk);
            service_en <= 1'b0;
        end
        @(posedge core_clk);
        irq_mask <= 4'h4;
        status_raw[2] <= 1'b0;
        look(16);
        chk({status_irq_n, status_sticky}, 5'h14);
        chk(status_live, 4'hB);
        @(posedge core_clk);
        irq_mask <= 4'h0;
        service_en <= 1'b1;
        look(8);
        chk({status_irq_n, status_sticky}, 5'h10);
        @(posedge core_clk);
        single_ended_drive_sel <= 20'h000E4;
        invert_neg <= 10'h002;
        route_sel <= 30'h1C0;
        look(12);
        chk(drive_strength, 20'h555E5);
        for (int k = 0; k < 6; k++) begin
            look(1);
            chk(clk_out_pos[1] ^ clk_out_neg[1], 1);
            chk({clk_out_pos[2], clk_out_pos[3] ^ clk_out_pos[4]}, 0);
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            bus_select_i2c <= (m == 0);
            spi_three_wire <= (m == 2);
            look(6);
            chk({iface_i2c, iface_spi4, iface_spi3}, 4 >> m);
        end
        @(posedge core_clk);
        zero_delay_en <= 1'b1;
        hitless_req <= 1'b1;
        look(6);
        chk({feedback_sel_ext, hitless_active}, 2'h2);
        @(posedge core_clk);
        sync_dis <= 10'h3FF;
        park_high <= 10'h2AB;
        global_output_en_n <= 1'b1;
        look(60);
        chk({clk_out_pos, clk_out_neg}, {2{10'h2AB}});
        chk(last_clock_output, 1);
        @(posedge core_clk);
        global_output_en_n <= 1'b0;
        sync_dis <= 10'h000;
        look(30);
        @(posedge core_clk);
        out_disable <= 10'h001;
        look(4);
        for (int k = 0; k < 4; k++) begin
            look(1);
            chk(clk_out_pos[0], 1);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            nvm_write <= 1'b1;
            nvm_write_data <= 16'hA5A0 + 16'(k);
            @(posedge core_clk);
            nvm_write <= 1'b0;
            @(negedge core_clk);
            chk(nvm_write_refused, k == 2);
            look(2);
            chk(nvm_writes_used, (k < 2) ? k + 1 : 2);
        end
        @(posedge core_clk);
        hard_reset <= 1'b1;
        @(posedge core_clk);
        hard_reset <= 1'b0;
        look(1);
        chk(divider_reset, 1);
        look(40);
        chk({clocks_running, default_config}, 17'h1A5A1);
        @(posedge core_clk);
        device_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        device_reset_n <= 1'b1;
        look(1);
        chk(divider_reset, 1);
        final_report();
    end
endmodule : tb
